// ---- src/bsf_cfg.svh ----
// Register offsets, field positions, reset values of the bias status block.
// Assumes inclusion by the top module only; the package does not include it.
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH
`define BSF_OFF_STATUS     12'h000
`define BSF_OFF_STREAM     12'h004
`define BSF_OFF_CTRL       12'h008
`define BSF_OFF_SWCLR      12'h00c
`define BSF_OFF_QUEUE      12'h010
`define BSF_BIT_BUSY       11
`define BSF_BIT_RESTART    10
`define BSF_BIT_EMPTY      9
`define BSF_BIT_OVER       8
`define BSF_BIT_CTRL_MODE  0
`define BSF_BIT_CTRL_DIE   1
`define BSF_BIT_FIRE       6
`define BSF_BIT_ARM        5
`define BSF_STREAM_RST     16'h0000
`define BSF_EMPTY_TAG      4'hf
`define BSF_RESET_CYCLES   4'h8
`endif

// ---- src/bsf_pkg.sv ----
// Types shared by the bias status block.
// Assumes the configuration header sits beside it.
package bsf_pkg;
  typedef struct packed {
    logic [7:0] stream_word_count;
    logic [7:0] stream_start_addr;
  } bsf_stream_s;

  typedef struct packed {
    logic [1:0] hi;
    logic [1:0] lo;
  } bsf_pair_s;

  typedef struct packed {
    logic       ch2_current_above;
    logic       ch2_current_below;
    logic       ch2_temp_above;
    logic       ch2_temp_below;
    logic       ch1_current_above;
    logic       ch1_current_below;
    logic       ch1_temp_above;
    logic       ch1_temp_below;
  } bsf_alarm_s;

  typedef enum logic [1:0] {
    BSF_RST_IDLE  = 2'b00,
    BSF_RST_ARMED = 2'b01,
    BSF_RST_RUN   = 2'b10
  } bsf_rst_e;
endpackage

// ---- src/bsf_top.sv ----
// Status flags and table-streaming setup registers on an AHB-Lite slave.
// Assumes alarm, queue and arithmetic events arrive as same-clock pulses.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`include "bsf_cfg.svh"

// Behaviour
// RULE1 - Busy bit follows arithmetic activity; reads one from reset.
// RULE2 - Restart bit sets after full software reset, clears on status read.
// RULE3 - Empty bit high while queue holds nothing, low once written.
// RULE4 - Monitoring mode: overflow latches, clears on status read.
// RULE5 - Streaming mode: bit shows queue full, clears after one word leaves.
// RULE6 - Channel 2 high-current alarm latches, clears on status read.
// RULE7 - Channel 2 low-current alarm latches, clears on status read.
// RULE8 - Channel 2 high-temperature alarm latches, clears on status read.
// RULE9 - Channel 2 low-temperature alarm latches, clears on status read.
// RULE10 - Die-temperature option routes die alarms into channel 2 current bits.
// RULE11 - With that option, channel 2 temperature bits are don't care.
// RULE12 - Channel 1 high-current alarm latches, clears on status read.
// RULE13 - Channel 1 low-current alarm latches, clears on status read.
// RULE14 - Channel 1 high-temperature alarm latches, clears on status read.
// RULE15 - Channel 1 low-temperature alarm latches, clears on status read.
// RULE16 - Upper setup byte plus one gives words written, up to 256.
// RULE17 - Lower setup byte is the first word address; both reset zero.
// RULE18 - Empty queue read returns tag all ones with status contents.
// RULE19 - Full reset only when arm was written earlier, then fire written.
// RULE20 - Clear-on-read happens after capture; same-cycle events survive.
module bsf_top
  import bsf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        calc_active,
  input  wire logic        queue_write,
  input  wire logic        queue_read,
  input  wire logic        queue_is_empty,
  input  wire logic        queue_is_full,
  input  wire logic        queue_overflow,
  input  wire logic [11:0] queue_head,
  input  wire logic [3:0]  queue_head_tag,
  input  wire bsf_alarm_s  alarm_event,
  input  wire bsf_pair_s   die_alarm_event,
  output bsf_stream_s      stream_setup,
  output logic             stream_mode,
  output logic             die_temp_on_ch2,
  output logic             total_reset_pulse,
  output logic             queue_pop
);

  logic [31:0] rdata_r;
  logic        busy_r;
  logic        restart_r;
  logic        empty_r;
  logic        over_r;
  bsf_alarm_s  alarm_r;
  bsf_stream_s stream_r;
  logic        mode_r;
  logic        die_r;
  bsf_rst_e    rst_state_r;
  bsf_rst_e    rst_state_nxt;
  logic [3:0]  rst_cnt_r;
  logic        reset_pulse_r;
  logic        pop_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;

  // Captures of reset-sensitive inputs are plain same-clock signals.
  wire         addr_phase = hsel & hready & htrans[1];
  wire         rd_now     = addr_phase & ~hwrite;
  wire         rd_status  = rd_now & (haddr == `BSF_OFF_STATUS);
  wire         rd_queue   = rd_now & (haddr == `BSF_OFF_QUEUE);
  wire         wr_stream  = wr_pend_r & (wr_addr_r == `BSF_OFF_STREAM);
  wire         wr_ctrl    = wr_pend_r & (wr_addr_r == `BSF_OFF_CTRL);
  wire         wr_swclr   = wr_pend_r & (wr_addr_r == `BSF_OFF_SWCLR);
  wire         fire_bit   = hwdata[`BSF_BIT_FIRE];
  wire         arm_bit    = hwdata[`BSF_BIT_ARM];
  wire         rst_done   = (rst_state_r == BSF_RST_RUN) &&
                            (rst_cnt_r == `BSF_RESET_CYCLES);

  // The die alarms take over the channel 2 current positions when enabled.
  wire         die_sel    = die_r;
  wire         c2_hi_set  = die_sel ? die_alarm_event.hi[0]
                                    : alarm_event.ch2_current_above; // RULE10
  wire         c2_lo_set  = die_sel ? die_alarm_event.lo[0]
                                    : alarm_event.ch2_current_below; // RULE10

  // Channel 2 temperature bits keep latching; software must ignore them.
  wire         c2_th_set  = alarm_event.ch2_temp_above; // RULE11
  wire         c2_tl_set  = alarm_event.ch2_temp_below; // RULE11

  wire [15:0]  status_word = {4'h0, busy_r, restart_r, empty_r, over_r,
                              alarm_r};

  wire [15:0]  queue_word  = queue_is_empty ?
                             {`BSF_EMPTY_TAG, status_word[11:0]}
                             : {queue_head_tag, queue_head}; // RULE18

  wire [31:0]  rd_mux = (haddr == `BSF_OFF_STATUS) ? {16'h0000, status_word}
                      : (haddr == `BSF_OFF_STREAM) ? {16'h0000, stream_r}
                      : (haddr == `BSF_OFF_CTRL)   ?
                        {30'h0, die_r, mode_r}
                      : (haddr == `BSF_OFF_QUEUE)  ? {16'h0000, queue_word}
                      : 32'h00000000;

  // Set beats clear so an alarm during the read reaches the next read.
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  always_comb begin
    rst_state_nxt = rst_state_r;
    unique case (rst_state_r)
      BSF_RST_IDLE: begin
        if (wr_swclr && arm_bit && !fire_bit) begin
          rst_state_nxt = BSF_RST_ARMED;
        end
      end
      BSF_RST_ARMED: begin
        if (wr_swclr && fire_bit) begin
          rst_state_nxt = BSF_RST_RUN; // RULE19
        end else if (wr_swclr && !arm_bit) begin
          rst_state_nxt = BSF_RST_IDLE;
        end
      end
      BSF_RST_RUN: begin
        if (rst_done) begin
          rst_state_nxt = BSF_RST_IDLE;
        end
      end
      default: rst_state_nxt = BSF_RST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      rdata_r   <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= haddr;
      rdata_r   <= rd_now ? rd_mux : 32'h00000000; // RULE20
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stream_r <= `BSF_STREAM_RST; // RULE17
      mode_r   <= 1'b0;
      die_r    <= 1'b0;
    end else begin
      if (wr_stream) begin
        stream_r <= hwdata[15:0]; // RULE16 RULE17
      end
      if (wr_ctrl) begin
        mode_r <= hwdata[`BSF_BIT_CTRL_MODE];
        die_r  <= hwdata[`BSF_BIT_CTRL_DIE];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_state_r   <= BSF_RST_IDLE;
      rst_cnt_r     <= 4'h0;
      reset_pulse_r <= 1'b0;
      restart_r     <= 1'b0;
    end else begin
      rst_state_r   <= rst_state_nxt;
      rst_cnt_r     <= (rst_state_r == BSF_RST_RUN) ?
                       rst_cnt_r + 4'h1 : 4'h0;
      reset_pulse_r <= (rst_state_r == BSF_RST_ARMED) &&
                       (rst_state_nxt == BSF_RST_RUN); // RULE19
      restart_r     <= sticky(restart_r, rst_done, rd_status); // RULE2
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r  <= 1'b1; // RULE1
      empty_r <= 1'b0;
      over_r  <= 1'b0;
      pop_r   <= 1'b0;
    end else begin
      busy_r  <= calc_active; // RULE1
      empty_r <= queue_is_empty & ~queue_write; // RULE3
      pop_r   <= rd_queue & ~queue_is_empty;
      if (mode_r) begin
        over_r <= queue_is_full & ~queue_read; // RULE5
      end else begin
        over_r <= sticky(over_r, queue_overflow, rd_status); // RULE4
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_r <= '0;
    end else begin
      alarm_r.ch2_current_above <= sticky(alarm_r.ch2_current_above,
                                          c2_hi_set, rd_status); // RULE6
      alarm_r.ch2_current_below <= sticky(alarm_r.ch2_current_below,
                                          c2_lo_set, rd_status); // RULE7
      alarm_r.ch2_temp_above    <= sticky(alarm_r.ch2_temp_above,
                                          c2_th_set, rd_status); // RULE8
      alarm_r.ch2_temp_below    <= sticky(alarm_r.ch2_temp_below,
                                          c2_tl_set, rd_status); // RULE9
      alarm_r.ch1_current_above <= sticky(alarm_r.ch1_current_above,
                          alarm_event.ch1_current_above, rd_status); // RULE12
      alarm_r.ch1_current_below <= sticky(alarm_r.ch1_current_below,
                          alarm_event.ch1_current_below, rd_status); // RULE13
      alarm_r.ch1_temp_above    <= sticky(alarm_r.ch1_temp_above,
                          alarm_event.ch1_temp_above, rd_status); // RULE14
      alarm_r.ch1_temp_below    <= sticky(alarm_r.ch1_temp_below,
                          alarm_event.ch1_temp_below, rd_status); // RULE15
    end
  end

  // Zero-wait slave: every transfer completes in its first data phase.
  assign hrdata            = rdata_r;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign stream_setup      = stream_r;
  assign stream_mode       = mode_r;
  assign die_temp_on_ch2   = die_r;
  assign total_reset_pulse = reset_pulse_r;
  assign queue_pop         = pop_r;

endmodule

// ---- dv/bsf_chk.sv ----
// Port checker for the status flag and stream setup block.
// Assumes hready is wired back from hreadyout by the bench.
module bsf_chk
  import bsf_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        calc_active,
  input wire logic        queue_write,
  input wire logic        queue_is_empty,
  input wire bsf_stream_s stream_setup,
  input wire logic        stream_mode,
  input wire logic        die_temp_on_ch2,
  input wire logic        total_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  wire tk = hsel && hready && htrans[1];
  wire rd = tk && !hwrite;
  wire rs = rd && haddr == 12'h000;
  wire rq = rd && haddr == 12'h010;
  wire ws = tk && hwrite && haddr == 12'h004;
  wire wc = tk && hwrite && haddr == 12'h008;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  busy_flag_a: assert property (rs && $stable(calc_active) ##1
    $stable(calc_active) |-> hrdata[11] == $past(calc_active))
    else $error("busy bit wrong");
  empty_flag_a: assert property (rs && $stable(queue_is_empty) &&
    !$past(queue_write) ##1 $stable(queue_is_empty) |->
    hrdata[9] == $past(queue_is_empty))
    else $error("empty bit wrong");
  empty_tag_a: assert property (rq && queue_is_empty ##1
    queue_is_empty |-> hrdata[15:12] == 4'hf) else $error("no empty tag");
  idle_data_a: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  upper_zero_a: assert property ($past(rd) |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or error");
  stream_load_a: assert property (ws |=> ##1
    stream_setup == $past(hwdata[15:0])) else $error("setup not written");
  stream_hold_a: assert property (!$past(ws, 2) |->
    $stable(stream_setup)) else $error("setup changed unasked");
  ctrl_load_a: assert property (wc |=> ##1
    {die_temp_on_ch2, stream_mode} == $past(hwdata[1:0]))
    else $error("control bits not written");
  fire_pulse_a: assert property (total_reset_pulse |=>
    !total_reset_pulse) else $error("reset pulse too long");
endmodule

bind bsf_top bsf_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .calc_active(calc_active), .queue_write(queue_write),
  .queue_is_empty(queue_is_empty),
  .stream_setup(stream_setup), .stream_mode(stream_mode),
  .die_temp_on_ch2(die_temp_on_ch2), .total_reset_pulse(total_reset_pulse));

// ---- dv/bsf_top_test.sv ----
// Self-checking bench for the status flag and stream setup block.
// Assumes a single AHB-Lite master, this bench, and one slave.
module bsf_top_test
  import bsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp = 0;
  logic calc_active = 0, queue_write = 0, queue_read = 0;
  logic queue_is_empty = 1, queue_is_full = 0, queue_overflow = 0;
  logic [11:0] haddr = '0, queue_head = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] queue_head_tag = '0;
  logic [31:0] hwdata = '0, hrdata, m;
  logic hreadyout, hresp, stream_mode, die_temp_on_ch2;
  logic total_reset_pulse, queue_pop;
  bsf_alarm_s alarm_event = '0;
  bsf_pair_s die_alarm_event = '0;
  bsf_stream_s stream_setup;
  wire hready = hreadyout;
  int n_fail = 0, total_checks = 0, cyc = 0, seed = 84, npulse = 0;
  int npop = 0;
  logic [31:0] eq[$], mq[$];
  logic [7:0] av;
  logic [15:0] sv;
  bsf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .calc_active(calc_active), .queue_write(queue_write),
    .queue_read(queue_read), .queue_is_empty(queue_is_empty),
    .queue_is_full(queue_is_full), .queue_overflow(queue_overflow),
    .queue_head(queue_head), .queue_head_tag(queue_head_tag),
    .alarm_event(alarm_event), .die_alarm_event(die_alarm_event),
    .stream_setup(stream_setup), .stream_mode(stream_mode),
    .die_temp_on_ch2(die_temp_on_ch2),
    .total_reset_pulse(total_reset_pulse), .queue_pop(queue_pop));
  initial forever #20 hclk = ~hclk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Reads note their expectation here; the monitor compares in data phase.
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d, e, k);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d; dp <= !w;
    if (!w) begin
      eq.push_back(e); mq.push_back(k);
    end
    do @(posedge hclk); while (hready !== 1'b1);
    dp <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, k);
    bus(a, 0, 32'h0, e, k);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1, d, 32'h0, 32'h0);
  endtask
  always @(posedge hclk) begin
    npulse += total_reset_pulse;
    npop += queue_pop;
    if (dp === 1'b1) begin
      m = mq.pop_front();
      chk("hrdata", eq.pop_front() & m, hrdata & m);
    end
    if (++cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    rd(12'h004, 32'h0, 32'hffffffff);
    calc_active <= 1;
    rd(12'h000, 32'h0a00, 32'hffff0fff);
    calc_active <= 0; queue_write <= 1; queue_is_empty <= 0;
    @(posedge hclk) queue_write <= 0;
    rd(12'h000, 32'h0, 32'hffff0fff);
    $display("busy and empty test done");
    for (int i = 0; i < 6; i++) begin
      av = 8'($random(seed));
      @(posedge hclk) alarm_event <= av;
      @(posedge hclk) alarm_event <= '0;
      rd(12'h000, {24'h0, av}, 32'hff);
      rd(12'h000, 32'h0, 32'hff);
    end
    fork
      rd(12'h000, 32'h0, 32'h1);
      begin
        @(posedge hclk) alarm_event <= 8'h01;
        @(posedge hclk) alarm_event <= '0;
      end
    join
    rd(12'h000, 32'h1, 32'h1);
    $display("alarm test done");
    @(posedge hclk) queue_overflow <= 1;
    @(posedge hclk) queue_overflow <= 0;
    rd(12'h000, 32'h100, 32'h100);
    rd(12'h000, 32'h0, 32'h100);
    wr(12'h008, 32'h1);
    queue_is_full <= 1;
    rd(12'h000, 32'h100, 32'h100);
    rd(12'h000, 32'h100, 32'h100);
    queue_is_full <= 0; queue_read <= 1;
    @(posedge hclk) queue_read <= 0;
    rd(12'h000, 32'h0, 32'h100);
    wr(12'h008, 32'h2);
    rd(12'h008, 32'h2, 32'hffffffff);
    @(posedge hclk) die_alarm_event <= 4'h4;
    @(posedge hclk) die_alarm_event <= '0;
    rd(12'h000, 32'h80, 32'hc0);
    wr(12'h008, 32'h0);
    $display("overflow and die test done");
    for (int i = 0; i < 3; i++) begin
      sv = i > 0 ? 16'($random(seed)) : 16'hff00;
      wr(12'h004, {16'hffff, sv});
      rd(12'h004, {16'h0, sv}, 32'hffffffff);
      chk("stream_setup", {16'h0, sv}, {16'h0, stream_setup});
    end
    sv = 16'($random(seed));
    queue_head_tag <= sv[15:12]; queue_head <= sv[11:0];
    rd(12'h010, {16'h0, sv}, 32'hffffffff);
    queue_is_empty <= 1; queue_head <= 12'($random(seed));
    rd(12'h010, 32'hf200, 32'hffffffff);
    chk("queue_pops", 32'h1, npop);
    rd(12'h100, 32'h0, 32'hffffffff);
    $display("stream and queue test done");
    wr(12'h00c, 32'h40);
    repeat (12) @(posedge hclk);
    rd(12'h000, 32'h0, 32'h400);
    wr(12'h00c, 32'h20);
    wr(12'h00c, 32'h40);
    repeat (12) @(posedge hclk);
    rd(12'h000, 32'h400, 32'h400);
    rd(12'h000, 32'h0, 32'h400);
    chk("reset_pulses", 32'h1, npulse);
    $display("full reset test done");
    @(posedge hclk);
    give_verdict();
  end
endmodule
